//--- verilog/mbc_regs.svh
// address map and timing counts for the memory bus cycle controller
`ifndef MBC_REGS_SVH
`define MBC_REGS_SVH
`define MBC_CYC_FAST 3'h1
`define MBC_CYC_SFR 3'h2
`define MBC_CYC_FLASH_LONG 3'h4
`define MBC_SFR_BASE 16'h0000
`define MBC_SFR_LAST 16'h02FF
`define MBC_RAM_BASE 16'h0400
`define MBC_RAM_LAST 16'h0FFF
`define MBC_DFL_BASE 16'h3000
`define MBC_DFL_LAST 16'h3FFF
`define MBC_W16_BASE 16'h0040
`define MBC_W16_LAST 16'h01FF
`endif

//--- verilog/mbc_pkg.sv
// types shared by the memory bus cycle controller
package mbc_pkg;
  typedef enum logic [2:0] {
    MBC_AREA_FAST = 3'b001,
    MBC_AREA_SFR = 3'b010,
    MBC_AREA_DFL = 3'b100
  } mbc_area_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbc_req_s;

  typedef struct packed {
    logic strobe;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbc_mem_s;
endpackage

//--- verilog/mbc_bus_ctrl.sv
// cpu to on-chip memory bus cycle controller
`timescale 1ns/1ps
`include "mbc_regs.svh"
module mbc_bus_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mbc_pkg::mbc_req_s cpu_req_i,
  input wire logic data_flash_wait_select_i,
  input wire logic [15:0] mem_rdata_i,
  output mbc_pkg::mbc_mem_s mem_o,
  output logic cpu_ready_o,
  output logic [15:0] cpu_rdata_o,
  output logic busy_o
);
  import mbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // sequencer states: one access at a time, split words use both
  typedef enum logic [2:0] {
    MBC_IDLE = 3'b001,
    MBC_LOW = 3'b010,
    MBC_HIGH = 3'b100
  } mbc_state_e;

  ////////////////////////////////////////////////////////////////////////
  // address decode and access timing helpers
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic mbc_area_e area_of(input logic [15:0] a);
    if (in_range(a, `MBC_SFR_BASE, `MBC_SFR_LAST)) begin
      area_of = MBC_AREA_SFR;
    end else if (in_range(a, `MBC_DFL_BASE, `MBC_DFL_LAST)) begin
      area_of = MBC_AREA_DFL;
    end else begin
      area_of = MBC_AREA_FAST;
    end
  endfunction

  function automatic logic [2:0] cycles_of(input mbc_area_e ar,
                                          input logic long_wait);
    // the wait select stretches flash only, never the register area
    case (ar)
      MBC_AREA_SFR: cycles_of = `MBC_CYC_SFR;
      MBC_AREA_DFL: cycles_of = long_wait ? `MBC_CYC_FLASH_LONG
                                          : `MBC_CYC_SFR;
      default: cycles_of = `MBC_CYC_FAST;
    endcase
  endfunction

  // a word in the listed register block goes out whole only when it is
  // even-aligned; an odd start would straddle two registers, so it splits
  function automatic logic goes_wide(input logic [15:0] a,
                                     input logic word);
    goes_wide = word && !a[0] &&
                in_range(a, `MBC_W16_BASE, `MBC_W16_LAST);
  endfunction

  // the byte path carries its data on the low lane only
  function automatic logic [15:0] low_lane(input logic [7:0] b);
    low_lane = {8'h00, b};
  endfunction

  // true on the final clock of the byte or wide access in flight
  function automatic logic last_cycle(input logic [2:0] cnt,
                                      input logic [2:0] len);
    last_cycle = (cnt == len);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sequencer and the request captured when it is taken
  mbc_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] len_q, len_d;
  logic write_q, write_d;
  logic wide_q, wide_d;
  logic split_q, split_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [7:0] low_q, low_d;
  // registered outputs toward both sides
  mbc_mem_s mem_q, mem_d;
  logic ready_q, ready_d;
  logic busy_q, busy_d;
  logic [15:0] rdata_q, rdata_d;
  logic wide_path;
  mbc_area_e req_area;

  assign req_area = area_of(cpu_req_i.addr);
  assign wide_path = goes_wide(cpu_req_i.addr, cpu_req_i.word);

  ////////////////////////////////////////////////////////////////////////
  // one access holds strobe for len clocks and samples read data on the
  // last; a split word chains its byte at addr + 1 straight after the one at addr,
  // and ready follows one clock after the final strobe clock
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    len_d = len_q;
    write_d = write_q;
    wide_d = wide_q;
    split_d = split_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    low_d = low_q;
    mem_d = mem_q;
    ready_d = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      MBC_IDLE: begin
        mem_d.strobe = 1'b0;
        // requests are taken here only; valid while busy is ignored
        if (cpu_req_i.valid) begin
          len_d = cycles_of(req_area, data_flash_wait_select_i);
          cnt_d = 3'h1;
          write_d = cpu_req_i.write;
          addr_d = cpu_req_i.addr;
          wdata_d = cpu_req_i.wdata;
          wide_d = wide_path;
          split_d = cpu_req_i.word && !wide_path;
          mem_d.strobe = 1'b1;
          mem_d.write = cpu_req_i.write;
          mem_d.wide = wide_path;
          mem_d.addr = cpu_req_i.addr;
          // byte path carries the low byte first
          mem_d.wdata = wide_path ? cpu_req_i.wdata
                        : low_lane(cpu_req_i.wdata[7:0]);
          state_d = MBC_LOW;
        end
      end
      MBC_LOW: begin
        if (last_cycle(cnt_q, len_q)) begin
          mem_d.strobe = 1'b0;
          if (split_q) begin
            // keep the low byte; the high byte at addr + 1 follows without a gap
            low_d = mem_rdata_i[7:0];
            mem_d.strobe = 1'b1;
            mem_d.addr = addr_q + 16'h0001;
            mem_d.wdata = low_lane(wdata_q[15:8]);
            cnt_d = 3'h1;
            state_d = MBC_HIGH;
          end else begin
            ready_d = 1'b1;
            rdata_d = wide_q ? mem_rdata_i
                      : low_lane(mem_rdata_i[7:0]);
            state_d = MBC_IDLE;
          end
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      MBC_HIGH: begin
        if (last_cycle(cnt_q, len_q)) begin
          mem_d.strobe = 1'b0;
          ready_d = 1'b1;
          // little-endian: the byte at addr + 1 is the upper half
          rdata_d = {mem_rdata_i[7:0], low_q};
          state_d = MBC_IDLE;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default: begin
        state_d = MBC_IDLE;
        mem_d.strobe = 1'b0;
      end
    endcase
    // busy leaves a flop like every other output
    busy_d = (state_d != MBC_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    // constants only, so outputs read zero all through reset
    if (rst_i) begin
      state_q <= MBC_IDLE;
      cnt_q <= 3'h0;
      len_q <= 3'h0;
      write_q <= 1'b0;
      wide_q <= 1'b0;
      split_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      low_q <= 8'h00;
      mem_q <= '0;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      write_q <= write_d;
      wide_q <= wide_d;
      split_q <= split_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      low_q <= low_d;
      mem_q <= mem_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign mem_o = mem_q;
  assign cpu_ready_o = ready_q;
  assign cpu_rdata_o = rdata_q;
  assign busy_o = busy_q;
endmodule

//--- dv/mbc_bus_ctrl_assertions.sv
// port checks for the bus cycle controller
`timescale 1ns/1ps
module mbc_bus_ctrl_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mbc_pkg::mbc_req_s cpu_req_i,
  input wire logic data_flash_wait_select_i,
  input wire logic [15:0] mem_rdata_i,
  input wire mbc_pkg::mbc_mem_s mem_o,
  input wire logic cpu_ready_o,
  input wire logic [15:0] cpu_rdata_o,
  input wire logic busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire tk = cpu_req_i.valid && !busy_o;
  wire [15:0] a = cpu_req_i.addr;
  wire sfr = a <= 16'h02ff;
  wire dfl = a[15:12] == 4'h3;
  wire bt = tk && !cpu_req_i.word;
  wire ws = data_flash_wait_select_i;
  wire wd = tk && cpu_req_i.word;
  sequence s1; mem_o.strobe ##1 cpu_ready_o; endsequence
  sequence s2; mem_o.strobe[*2] ##1 cpu_ready_o; endsequence
  sequence s4; mem_o.strobe[*4] ##1 cpu_ready_o; endsequence
  fast_byte_a:
    assert property (bt && !sfr && !dfl |=> s1) else $error("fast");
  sfr_byte_a:
    assert property (bt && sfr |=> s2) else $error("sfr");
  flash_short_a:
    assert property (bt && dfl && !ws |=> s2) else $error("flash");
  flash_long_a:
    assert property (bt && dfl && ws |=> s4) else $error("long");
  wide_once_a: assert property (wd && !a[0] && a >= 16'h0040
    && a <= 16'h01ff |=> mem_o.wide ##0 s2) else $error("wide");
  split_order_a: assert property (wd && !sfr && !dfl
    |=> mem_o.addr == $past(a) ##1 mem_o.addr == $past(a, 2) + 16'h0001
    ##1 cpu_ready_o) else $error("split");
  ready_pulse_a:
    assert property (cpu_ready_o |=> !cpu_ready_o) else $error("pulse");
  idle_ready_a:
    assert property (cpu_ready_o |-> !busy_o) else $error("idle");
endmodule
bind mbc_bus_ctrl mbc_bus_ctrl_assertions u_chk (.*);

//--- dv/mbc_mem_model.sv
// byte-wide memory answering the controller
`timescale 1ns/1ps
module mbc_mem_model (
  input wire logic clk_i,
  input wire mbc_pkg::mbc_mem_s m_i,
  output logic [15:0] rd_o
);
  logic [7:0] m [0:65535];
  logic [15:0] l_q = '0;
  wire [15:0] a = m_i.addr;
  always @(posedge clk_i) begin
    if (m_i.strobe && m_i.write) m[a] <= m_i.wdata[7:0];
    if (m_i.strobe && m_i.write && m_i.wide)
      m[a + 16'h0001] <= m_i.wdata[15:8];
    l_q <= rd_o;
  end
  // idle bus toggles so stale data cannot pass
  assign rd_o = m_i.strobe ? {m[a + 16'h0001], m[a]} : ~l_q;
endmodule

//--- dv/cpu_memory_bus_cycle_control_tb_top.sv
// bench for the bus cycle controller
`timescale 1ns/1ps
module cpu_memory_bus_cycle_control_tb_top;
  import mbc_pkg::*;
  logic clk = 0, rst = 1, ws = 0, rdy, bsy;
  logic [15:0] md, rd;
  mbc_req_s req = '0;
  mbc_mem_s mem;
  int n_mismatch = 0, checks_done = 0;
  always #50 clk = ~clk;
  mbc_bus_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst), .cpu_req_i(req),
    .data_flash_wait_select_i(ws), .mem_rdata_i(md), .mem_o(mem),
    .cpu_ready_o(rdy), .cpu_rdata_o(rd), .busy_o(bsy));
  mbc_mem_model u_mem (.clk_i(clk), .m_i(mem), .rd_o(md));
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  // called 1 ns after an edge; request taken at next edge
  task automatic acc(logic w, o, logic [15:0] a, d, logic f, int n,
    logic [15:0] e);
    int c = 1;
    req = '{1'b1, w, o, a, d};
    ws = f;
    @(posedge clk);
    #1 req.valid = 0;
    while (rdy !== 1'b1 && c < 20) @(posedge clk) #1 c++;
    chk("cycles", 16'(n), 16'(c));
    if (!w) chk("rdata", e, rd);
    if (c == 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic t_fast;
    acc(1, 1, 16'h0400, 16'hbeef, 0, 3, 0);
    acc(0, 1, 16'h0400, 0, 0, 3, 16'hbeef);
    acc(0, 0, 16'h0401, 0, 0, 2, 16'h00be);
  endtask
  task automatic t_flash;
    for (int f = 0; f < 2; f++) begin
      acc(1, 1, 16'h3002, 16'h1234, f[0], f ? 9 : 5, 0);
      acc(0, 0, 16'h3003, 0, f[0], f ? 5 : 3, 16'h0012);
    end
  endtask
  task automatic t_wide;
    acc(1, 1, 16'h0040, 16'hc3a5, 0, 3, 0);
    acc(0, 1, 16'h0040, 0, 0, 3, 16'hc3a5);
    acc(0, 0, 16'h0041, 0, 0, 3, 16'h00c3);
  endtask
  task automatic t_sfr_split;
    acc(1, 1, 16'h0200, 16'h5a3c, 0, 5, 0);
    acc(0, 1, 16'h0200, 0, 0, 5, 16'h5a3c);
    acc(1, 0, 16'h0201, 16'h0077, 0, 3, 0);
    acc(0, 1, 16'h0200, 0, 0, 5, 16'h773c);
  endtask
  // reset in mid access: outputs drop at once, next access runs clean
  task automatic t_reset;
    req = '{1'b1, 1'b0, 1'b1, 16'h3000, 16'h0000};
    ws = 1;
    @(posedge clk);
    #1 req.valid = 0;
    chk("busy", 16'h0001, {15'h0000, bsy});
    @(posedge clk);
    #1 rst = 1;
    #1 chk("busy", 16'h0000, {15'h0000, bsy});
    chk("strobe", 16'h0000, {15'h0000, mem.strobe});
    chk("rdata", 16'h0000, rd);
    @(posedge clk);
    #1 rst = 0;
    acc(0, 1, 16'h3002, 0, 0, 5, 16'h1234);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    t_fast();
    t_flash();
    t_wide();
    t_sfr_split();
    t_reset();
    wrap_up();
  end
endmodule
